/* File: core/msc_defines.vh */
`ifndef MSC_DEFINES_VH
`define MSC_DEFINES_VH

// ----------------------------------------------------------------
// frame header capture
// ----------------------------------------------------------------
`define MSC_HDR_BYTES      36
`define MSC_HDR_BITS       288
`define MSC_ET_MACSEC      16'h88e5
`define MSC_SL_LIMIT       8'h30

// ----------------------------------------------------------------
// tag status encodings
// ----------------------------------------------------------------
`define MSC_TAG_UNTAGGED   2'h0
`define MSC_TAG_TAGGED     2'h1
`define MSC_TAG_BAD        2'h2
`define MSC_TAG_KAY        2'h3

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define MSC_OFF_CONFIG     8'h00
`define MSC_OFF_ENABLE     8'h04
`define MSC_OFF_EXACT_LO   8'h08
`define MSC_OFF_EXACT_HI   8'h0c
`define MSC_OFF_RANGE44_LO 8'h10
`define MSC_OFF_RANGE44_HI 8'h14
`define MSC_OFF_LOW_LO     8'h18
`define MSC_OFF_LOW_HI     8'h1c
`define MSC_OFF_HIGH_LO    8'h20
`define MSC_OFF_HIGH_HI    8'h24
`define MSC_OFF_PRIO_REMAP 8'h28
`define MSC_OFF_TAG_TYPES  8'h2c
`define MSC_OFF_STATUS     8'h30
`define MSC_OFF_DA_BASE    8'h40
`define MSC_OFF_ET_BASE    8'h90
`define MSC_OFF_ET_LAST    8'hac

// ----------------------------------------------------------------
// config register fields
// ----------------------------------------------------------------
`define MSC_CFG_ET_SRC     0
`define MSC_CFG_BYPASS     1
`define MSC_CFG_UP_EN      2
`define MSC_CFG_DEF_UP     4

// ----------------------------------------------------------------
// criterion enable bit positions
// ----------------------------------------------------------------
`define MSC_EN_DA0         0
`define MSC_EN_ET0         8
`define MSC_EN_ET10        16
`define MSC_EN_COMB8       24
`define MSC_EN_COMB9       25
`define MSC_EN_EXACT       26
`define MSC_EN_RANGE44     27
`define MSC_EN_RANGE       28
`define MSC_EN_COUNT       29

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define MSC_RST_EXACT      48'h01000ccccccc
`define MSC_RST_RANGE44    48'h0180c2000000
`define MSC_RST_QTPID      16'h8100
`define MSC_RST_STPID      16'h88a8
`define MSC_RST_REMAP      24'hfac688

`endif

/* File: core/msc_hdr_capture.v */
`timescale 1ns/10ps
`default_nettype none
`include "msc_defines.vh"

module msc_hdr_capture
(
   // clock and reset
   input  wire                      ref_clk,
   input  wire                      reset,
   input  wire                      ce,
   // byte stream, already qualified by ready
   input  wire                      take,
   input  wire [7:0]                data,
   input  wire                      sof,
   input  wire                      eof,
   input  wire                      status_frame,
   // captured header
   output reg  [`MSC_HDR_BITS-1:0]  hdr,
   output reg                       hdr_done
);

   reg [5:0] cnt;
   reg       busy;

   // ----------------------------------------------------------------
   // header store, byte 0 in the low bits
   // ----------------------------------------------------------------
   always @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         hdr      <= {`MSC_HDR_BITS{1'b0}};
         hdr_done <= 1'b0;
         cnt      <= 6'h00;
         busy     <= 1'b0;
      end
      else if (ce)
      begin
         hdr_done <= 1'b0;
         if (take && sof)
         begin
            if (!(status_frame && eof))
            begin
               hdr      <= {{(`MSC_HDR_BITS-8){1'b0}}, data};
               cnt      <= 6'h01;
               busy     <= !eof;
               hdr_done <= eof;
            end
         end
         else if (take && busy)
         begin
            hdr[cnt*8 +: 8] <= data;
            cnt             <= cnt + 6'h01;
            if (eof || cnt == `MSC_HDR_BYTES - 1)
            begin
               busy     <= 1'b0;
               hdr_done <= 1'b1;
            end
         end
      end
   end

endmodule // msc_hdr_capture
`default_nettype wire

/* File: core/msc_static_classifier.v */
// Overview of operation
// - three classifiers run in parallel per frame
// - tag status is one of four values
// - parsed ethertype skips up to two VLAN tags
// - control set when any enabled criterion matches
// - exact destination compare, programmable, fixed reset
// - 44-bit destination compare, low nibble ignored
// - inclusive unsigned destination address range
// - eight destination comparators enabled independently
// - sixteen ethertype comparators match independently
// - address or ethertype zero matching gives control
// - combined entries need both address and type
// - all criteria disabled after reset
// - mode selects first or parsed ethertype
// - sectag after source address, or bypass mode
// - ethertype not 88e5 means untagged
// - C clear E set gives KaY
// - listed sectag faults give bad tag
// - recognise Q and S tags, two stacked
// - vlan, stag, qtag and qinq flags
// - priority from first tag or default
// - outer and inner VLAN ids from tags
// - inner priority always remapped through table
// - single-byte status frames bypass all classifiers
// - tag status and control go downstream
`timescale 1ns/10ps
`default_nettype none
`include "msc_defines.vh"

module msc_static_classifier
(
   // clock, reset, enable
   input  wire         ref_clk,
   input  wire         reset,
   input  wire         ce,
   // apb slave
   input  wire         psel,
   input  wire         penable,
   input  wire         pwrite,
   input  wire [7:0]   paddr,
   input  wire [31:0]  pwdata,
   output reg  [31:0]  prdata,
   output reg          pready,
   output reg          pslverr,
   // frame byte stream
   input  wire         in_valid,
   input  wire [7:0]   in_data,
   input  wire         in_sof,
   input  wire         in_eof,
   input  wire         in_status_frame,
   output reg          in_ready,
   // classification results
   output reg          res_valid,
   input  wire         res_ready,
   output reg          res_control,
   output reg  [1:0]   res_tag_status,
   output reg          res_vlan_valid,
   output reg          res_stag_valid,
   output reg          res_qtag_valid,
   output reg          res_qinq_found,
   output reg  [2:0]   res_up,
   output reg  [11:0]  res_vid,
   output reg  [2:0]   res_inner_up,
   output reg  [11:0]  res_inner_vid,
   output reg  [15:0]  res_ethertype
);

   // ----------------------------------------------------------------
   // configuration
   // ----------------------------------------------------------------
   reg                    ethertype_source_select;
   reg                    tag_parse_bypass;
   reg                    up_enable;
   reg [2:0]              default_up;
   reg [`MSC_EN_COUNT-1:0] criterion_enable_mask;
   reg [47:0]             fixed_da_exact_value;
   reg [47:0]             fixed_da_range_value;
   reg [47:0]             da_range_low;
   reg [47:0]             da_range_high;
   reg [23:0]             inner_priority_remap;
   reg [15:0]             qtag_type;
   reg [15:0]             stag_type;
   reg [47:0]             da_compare_entry [0:9];
   reg [15:0]             ethertype_compare_entry [0:17];

   wire [`MSC_HDR_BITS-1:0] hdr;
   wire                     hdr_done;
   wire                     take;
   wire                     apb_write;
   wire                     next_res_valid;
   integer                  k;
   integer                  j;

   assign take      = in_valid && in_ready;
   assign apb_write = psel && penable && pready && pwrite;

   msc_hdr_capture u_capture
   (
      .ref_clk      (ref_clk),
      .reset        (reset),
      .ce           (ce),
      .take         (take),
      .data         (in_data),
      .sof          (in_sof),
      .eof          (in_eof),
      .status_frame (in_status_frame),
      .hdr          (hdr),
      .hdr_done     (hdr_done)
   );

   // ----------------------------------------------------------------
   // header field access
   // ----------------------------------------------------------------
   function [7:0] hb;
      input integer o;
      begin
         hb = hdr[o*8 +: 8];
      end
   endfunction

   function [15:0] hw;
      input integer o;
      begin
         hw = {hdr[o*8 +: 8], hdr[(o+1)*8 +: 8]};
      end
   endfunction

   function is_vlan;
      input [15:0] t;
      begin
         is_vlan = (t == qtag_type) || (t == stag_type);
      end
   endfunction

   // ----------------------------------------------------------------
   // vlan parsing
   // ----------------------------------------------------------------
   wire [47:0] da       = {hb(0), hb(1), hb(2), hb(3), hb(4), hb(5)};
   wire [15:0] first_et = hw(12);
   wire        v1       = is_vlan(first_et);
   wire        v2       = v1 && is_vlan(hw(16));
   reg  [4:0]  pe_off;
   always @*
   begin
      case ({v1, v2})
         2'b10:   pe_off = 5'd16;
         2'b11:   pe_off = 5'd20;
         default: pe_off = 5'd12;
      endcase
   end
   wire [15:0] parsed_et = hw(pe_off);
   wire [2:0]  inner_pcp = hdr[18*8+5 +: 3];

   // ----------------------------------------------------------------
   // sectag parsing
   // ----------------------------------------------------------------
   // tag position
   wire [4:0] st_off = tag_parse_bypass ? pe_off : 5'd12;
   wire [7:0] tci    = hb(st_off + 2);
   wire [7:0] sl     = hb(st_off + 3);
   wire [31:0] pn    = {hb(st_off + 4), hb(st_off + 5), hb(st_off + 6), hb(st_off + 7)};
   reg  [1:0] tag_status;
   always @*
   begin
      if (hw(st_off) != `MSC_ET_MACSEC)
         tag_status = `MSC_TAG_UNTAGGED;
      else if (tci[7])
         tag_status = `MSC_TAG_BAD;
      else if (!tci[2] && tci[3])
         tag_status = `MSC_TAG_KAY;
      else if ((tci[2] && !tci[3]) || (tci[5] && tci[6]) || (tci[5] && tci[4])
               || sl >= `MSC_SL_LIMIT || pn == 32'h00000000)
         tag_status = `MSC_TAG_BAD;
      else
         tag_status = `MSC_TAG_TAGGED;
   end

   // ----------------------------------------------------------------
   // control packet criteria
   // ----------------------------------------------------------------
   // compare type select
   wire [15:0] sel_et = ethertype_source_select ? parsed_et : first_et;
   wire [`MSC_EN_COUNT-1:0] hit;
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1)
      begin : g_cmp
         assign hit[`MSC_EN_DA0 + g]  = da == da_compare_entry[g];
         assign hit[`MSC_EN_ET0 + g]  = sel_et == ethertype_compare_entry[g];
         assign hit[`MSC_EN_ET10 + g] = sel_et == ethertype_compare_entry[10 + g];
      end
      for (g = 0; g < 2; g = g + 1)
      begin : g_comb
         assign hit[`MSC_EN_COMB8 + g] = (da == da_compare_entry[8 + g])
                                      && (sel_et == ethertype_compare_entry[8 + g]);
      end
   endgenerate
   assign hit[`MSC_EN_EXACT]   = da == fixed_da_exact_value;
   assign hit[`MSC_EN_RANGE44] = da[47:4] == fixed_da_range_value[47:4];
   assign hit[`MSC_EN_RANGE]   = (da >= da_range_low) && (da <= da_range_high);
   wire control = |(hit & criterion_enable_mask);

   // ----------------------------------------------------------------
   // result hold and input stall
   // ----------------------------------------------------------------
   // hold until accepted
   assign next_res_valid = hdr_done || (res_valid && !res_ready);

   always @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         res_valid      <= 1'b0;
         in_ready       <= 1'b0;
         res_control    <= 1'b0;
         res_tag_status <= `MSC_TAG_UNTAGGED;
         res_vlan_valid <= 1'b0;
         res_stag_valid <= 1'b0;
         res_qtag_valid <= 1'b0;
         res_qinq_found <= 1'b0;
         res_up         <= 3'h0;
         res_vid        <= 12'h000;
         res_inner_up   <= 3'h0;
         res_inner_vid  <= 12'h000;
         res_ethertype  <= 16'h0000;
      end
      else if (ce)
      begin
         res_valid <= next_res_valid;
         in_ready  <= !next_res_valid;
         if (hdr_done)
         begin
            res_control    <= control;
            res_tag_status <= tag_status;
            res_vlan_valid <= v1;
            res_stag_valid <= v1 && (first_et == stag_type);
            res_qtag_valid <= v1 && (first_et == qtag_type);
            res_qinq_found <= v2;
            res_up         <= (v1 && up_enable) ? hdr[14*8+5 +: 3] : default_up;
            res_vid        <= {hdr[14*8 +: 4], hb(15)};
            res_inner_vid  <= {hdr[18*8 +: 4], hb(19)};
            res_inner_up   <= inner_priority_remap[inner_pcp*3 +: 3];
            res_ethertype  <= parsed_et;
         end
      end
   end

   // ----------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------
   always @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         ethertype_source_select <= 1'b0;
         tag_parse_bypass        <= 1'b0;
         up_enable               <= 1'b0;
         default_up              <= 3'h0;
         criterion_enable_mask   <= {`MSC_EN_COUNT{1'b0}};
         fixed_da_exact_value    <= `MSC_RST_EXACT;
         fixed_da_range_value    <= `MSC_RST_RANGE44;
         da_range_low            <= 48'h000000000000;
         da_range_high           <= 48'h000000000000;
         inner_priority_remap    <= `MSC_RST_REMAP;
         qtag_type               <= `MSC_RST_QTPID;
         stag_type               <= `MSC_RST_STPID;
         for (k = 0; k < 10; k = k + 1)
            da_compare_entry[k] <= 48'h000000000000;
         for (k = 0; k < 18; k = k + 1)
            ethertype_compare_entry[k] <= 16'h0000;
      end
      else if (ce && apb_write)
      begin
         case (paddr)
            `MSC_OFF_CONFIG:
            begin
               ethertype_source_select <= pwdata[`MSC_CFG_ET_SRC];
               tag_parse_bypass        <= pwdata[`MSC_CFG_BYPASS];
               up_enable               <= pwdata[`MSC_CFG_UP_EN];
               default_up              <= pwdata[`MSC_CFG_DEF_UP +: 3];
            end
            `MSC_OFF_ENABLE:     criterion_enable_mask        <= pwdata[`MSC_EN_COUNT-1:0];
            `MSC_OFF_EXACT_LO:   fixed_da_exact_value[31:0]   <= pwdata;
            `MSC_OFF_EXACT_HI:   fixed_da_exact_value[47:32]  <= pwdata[15:0];
            `MSC_OFF_RANGE44_LO: fixed_da_range_value[31:0]   <= pwdata;
            `MSC_OFF_RANGE44_HI: fixed_da_range_value[47:32]  <= pwdata[15:0];
            `MSC_OFF_LOW_LO:     da_range_low[31:0]           <= pwdata;
            `MSC_OFF_LOW_HI:     da_range_low[47:32]          <= pwdata[15:0];
            `MSC_OFF_HIGH_LO:    da_range_high[31:0]          <= pwdata;
            `MSC_OFF_HIGH_HI:    da_range_high[47:32]         <= pwdata[15:0];
            `MSC_OFF_PRIO_REMAP: inner_priority_remap         <= pwdata[23:0];
            `MSC_OFF_TAG_TYPES:
            begin
               qtag_type <= pwdata[15:0];
               stag_type <= pwdata[31:16];
            end
            default:
            begin
               // entries 0..9: low word then address high half with type
               for (k = 0; k < 10; k = k + 1)
               begin
                  if (paddr == `MSC_OFF_DA_BASE + k * 8)
                     da_compare_entry[k][31:0] <= pwdata;
                  if (paddr == `MSC_OFF_DA_BASE + k * 8 + 4)
                  begin
                     da_compare_entry[k][47:32] <= pwdata[15:0];
                     ethertype_compare_entry[k] <= pwdata[31:16];
                  end
               end
               for (k = 0; k < 8; k = k + 1)
                  if (paddr == `MSC_OFF_ET_BASE + k * 4)
                     ethertype_compare_entry[10 + k] <= pwdata[15:0];
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // register reads
   // ----------------------------------------------------------------
   reg [31:0] rd_data;
   reg        rd_ok;
   always @*
   begin
      rd_data = 32'h00000000;
      rd_ok   = 1'b1;
      case (paddr)
         `MSC_OFF_CONFIG:     rd_data = {25'h0, default_up, 1'b0, up_enable,
                                         tag_parse_bypass, ethertype_source_select};
         `MSC_OFF_ENABLE:     rd_data = {3'h0, criterion_enable_mask};
         `MSC_OFF_EXACT_LO:   rd_data = fixed_da_exact_value[31:0];
         `MSC_OFF_EXACT_HI:   rd_data = {16'h0, fixed_da_exact_value[47:32]};
         `MSC_OFF_RANGE44_LO: rd_data = fixed_da_range_value[31:0];
         `MSC_OFF_RANGE44_HI: rd_data = {16'h0, fixed_da_range_value[47:32]};
         `MSC_OFF_LOW_LO:     rd_data = da_range_low[31:0];
         `MSC_OFF_LOW_HI:     rd_data = {16'h0, da_range_low[47:32]};
         `MSC_OFF_HIGH_LO:    rd_data = da_range_high[31:0];
         `MSC_OFF_HIGH_HI:    rd_data = {16'h0, da_range_high[47:32]};
         `MSC_OFF_PRIO_REMAP: rd_data = {8'h0, inner_priority_remap};
         `MSC_OFF_TAG_TYPES:  rd_data = {stag_type, qtag_type};
         `MSC_OFF_STATUS:     rd_data = {res_ethertype, 7'h0, res_valid, res_qinq_found,
                                         res_qtag_valid, res_stag_valid, res_vlan_valid,
                                         1'b0, res_tag_status, res_control};
         default:
         begin
            rd_ok = 1'b0;
            for (j = 0; j < 10; j = j + 1)
            begin
               if (paddr == `MSC_OFF_DA_BASE + j * 8)
               begin
                  rd_data = da_compare_entry[j][31:0];
                  rd_ok   = 1'b1;
               end
               if (paddr == `MSC_OFF_DA_BASE + j * 8 + 4)
               begin
                  rd_data = {ethertype_compare_entry[j], da_compare_entry[j][47:32]};
                  rd_ok   = 1'b1;
               end
            end
            for (j = 0; j < 8; j = j + 1)
               if (paddr == `MSC_OFF_ET_BASE + j * 4)
               begin
                  rd_data = {16'h0, ethertype_compare_entry[10 + j]};
                  rd_ok   = 1'b1;
               end
         end
      endcase
   end

   // no wait state: answer prepared in the setup cycle
   always @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         pready  <= 1'b0;
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end
      else if (ce)
      begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !rd_ok;
         if (psel && !penable)
            prdata <= pwrite ? 32'h00000000 : rd_data;
      end
   end

endmodule // msc_static_classifier
`default_nettype wire

/* File: verification/msc_static_classifier_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module msc_static_classifier_chk (
   // bus and byte stream
   input wire logic        ref_clk, reset, ce, psel, penable, pready, pslverr,
   input wire logic [31:0] prdata,
   input wire logic        in_valid, in_sof, in_eof, in_status_frame, in_ready,
   // results
   input wire logic        res_valid, res_ready, res_control, res_vlan_valid,
   input wire logic        res_stag_valid, res_qtag_valid, res_qinq_found,
   input wire logic [1:0]  res_tag_status,
   input wire logic [15:0] res_ethertype
);
   logic [7:0] cnt;
   wire        take = in_valid && in_ready;
   always @(posedge ref_clk or posedge reset)
      if (reset)
         cnt <= 8'h00;
      else if (take)
         cnt <= in_sof ? 8'h01 : cnt + {7'h00, cnt != 8'hff};
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset || !ce);
   property p_answer; psel && !penable |=> pready; endproperty
   a_answer: assert property (p_answer) else $error("no bus answer");
   property p_pulse; pready |=> !pready; endproperty
   a_pulse: assert property (p_pulse) else $error("ready too long");
   property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
   a_err: assert property (p_err) else $error("bad error answer");
   property p_block; res_valid |-> !in_ready; endproperty
   a_block: assert property (p_block) else $error("bytes taken while held");
   property p_accept; res_valid && res_ready |=> !res_valid && in_ready; endproperty
   a_accept: assert property (p_accept) else $error("accept not honoured");
   property p_hold;
      res_valid && !res_ready |=> res_valid && $stable({res_control, res_tag_status,
         res_vlan_valid, res_stag_valid, res_qtag_valid, res_qinq_found, res_ethertype});
   endproperty
   a_hold: assert property (p_hold) else $error("result moved while held");
   property p_latency;
      take && in_eof && !(in_sof && in_status_frame) && (in_sof || cnt < 8'h24)
         |-> ##2 res_valid;
   endproperty
   a_latency: assert property (p_latency) else $error("result late");
   property p_flags;
      $rose(res_valid) |-> res_vlan_valid == (res_stag_valid | res_qtag_valid)
         && !(res_stag_valid && res_qtag_valid) && (!res_qinq_found || res_vlan_valid);
   endproperty
   a_flags: assert property (p_flags) else $error("vlan flags inconsistent");
endmodule // msc_static_classifier_chk
bind msc_static_classifier msc_static_classifier_chk u_chk (.*);
`default_nettype wire

/* File: verification/msc_frame_partner.sv */
`timescale 1ns/10ps
`default_nettype none
module msc_frame_partner (
   // stream and result handshake
   input wire logic  ref_clk, in_ready, res_valid,
   output logic      in_valid, in_sof, in_eof, in_status_frame, res_ready,
   output logic [7:0] in_data
);
   logic [7:0] mem [0:63];
   int         stall = 0;
   int         wait_n = 0;
   initial {in_valid, in_sof, in_eof, in_status_frame, in_data} = '0;
   // each byte held until taken; data inverted when idle
   task automatic send(input int n, input bit st);
      for (int i = 0; i < n; i++)
      begin
         {in_valid, in_sof, in_eof, in_status_frame, in_data} <= {1'b1, i == 0, i == n - 1, st, mem[i]};
         do @(posedge ref_clk); while (in_ready !== 1'b1);
      end
      {in_valid, in_sof, in_eof, in_status_frame} <= 4'h0;
      in_data <= ~in_data;
   endtask
   always @(posedge ref_clk)
      if (res_valid && !res_ready && wait_n < stall)
         wait_n <= wait_n + 1;
      else
      begin
         res_ready <= res_valid && !res_ready;
         wait_n <= 0;
      end
endmodule // msc_frame_partner
`default_nettype wire

/* File: verification/msc_static_classifier_test.sv */
`timescale 1ns/10ps
`default_nettype none
module msc_static_classifier_test;
   // ---------------
   // signals
   // ---------------
   logic        ref_clk = 1'b0, reset = 1'b1, ce = 1'b1;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, seen, re;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, rq;
   wire  [31:0] prdata;
   wire         pready, pslverr, in_valid, in_sof, in_eof, in_status_frame, in_ready;
   wire         res_valid, res_ready, res_control, res_vlan_valid, res_stag_valid;
   wire         res_qtag_valid, res_qinq_found;
   wire  [7:0]  in_data;
   wire  [1:0]  res_tag_status;
   wire  [2:0]  res_up, res_inner_up;
   wire  [11:0] res_vid, res_inner_vid;
   wire  [15:0] res_ethertype;
   int          mismatches = 0, checks_done = 0, cycles = 0;
   logic [127:0] plain = {16'h0800, 112'h0};
   logic [7:0]  tci [9] = '{8'h0c, 8'h08, 8'h8c, 8'h04, 8'h6c, 8'h3c, 8'h0c, 8'h0c, 8'h0c};
   logic [7:0]  sl [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h30, 8'h2f, 8'h00};
   logic [1:0]  tag [9] = '{2'h1, 2'h3, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h1, 2'h2};
   msc_static_classifier uut (.*);
   msc_frame_partner p (.*);
   initial forever #10 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
      if (++cycles > 8000)
      begin
         mismatches++;
         wrap_up;
      end
   // ---------------
   // tasks
   // ---------------
   task wrap_up;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [47:0] exp, got);
      checks_done++;
      if (got !== exp)
      begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic apb(input bit wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rq = prdata;
      re = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
      apb(1'b0, a, 32'h0);
      chk("prdata", x, rq);
      chk("pslverr", xe, re);
   endtask
   task automatic frm(input logic [47:0] da, input logic [127:0] rest, input logic c,
                      input logic [1:0] t, input logic [15:0] et);
      for (int i = 0; i < 28; i++)
         p.mem[i] = i < 6 ? da[47 - 8 * i -: 8] : (i < 12 ? 8'h02 : rest[127 - 8 * (i - 12) -: 8]);
      @(posedge ref_clk);
      p.send(28, 1'b0);
      for (int i = 0; i < 60 && !(res_valid && res_ready); i++)
         @(posedge ref_clk);
      chk("accept", 1'b1, res_valid && res_ready);
      chk("control", c, res_control);
      chk("tag", t, res_tag_status);
      chk("ethertype", et, res_ethertype);
   endtask
   task automatic vchk(input logic [3:0] f, input logic [2:0] u);
      chk("flags", f, {res_vlan_valid, res_stag_valid, res_qtag_valid, res_qinq_found});
      chk("up", u, res_up);
   endtask
   // ---------------
   // tests
   // ---------------
   initial
   begin
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      rd(8'h08, 32'h0ccccccc, 1'b0);
      rd(8'h14, 32'h00000180, 1'b0);
      rd(8'h04, 32'h0, 1'b0);
      rd(8'hfc, 32'h0, 1'b1);
      $display("test registers done");
      frm(48'h01000ccccccc, plain, 1'b0, 2'h0, 16'h0800);
      wr(8'h04, 32'h04000000);
      frm(48'h01000ccccccc, plain, 1'b1, 2'h0, 16'h0800);
      wr(8'h08, 32'h11223344);
      frm(48'h01000ccccccc, plain, 1'b0, 2'h0, 16'h0800);
      wr(8'h04, 32'h08000000);
      frm(48'h0180c200000e, plain, 1'b1, 2'h0, 16'h0800);
      frm(48'h0180c200001e, plain, 1'b0, 2'h0, 16'h0800);
      wr(8'h04, 32'h10000000);
      wr(8'h18, 32'h00000005);
      wr(8'h20, 32'h00000005);
      frm(48'h5, plain, 1'b1, 2'h0, 16'h0800);
      frm(48'h6, plain, 1'b0, 2'h0, 16'h0800);
      wr(8'h04, 32'h00000101);
      wr(8'h44, 32'h888e0000);
      frm(48'h0a, {32'h81000001, 16'h888e, 80'h0}, 1'b0, 2'h0, 16'h888e);
      wr(8'h00, 32'h00000001);
      frm(48'h0a, {32'h81000001, 16'h888e, 80'h0}, 1'b1, 2'h0, 16'h888e);
      frm(48'h00, plain, 1'b1, 2'h0, 16'h0800);
      wr(8'h04, 32'h01000000);
      wr(8'h80, 32'h000000aa);
      wr(8'h84, 32'h08000000);
      frm(48'haa, plain, 1'b1, 2'h0, 16'h0800);
      frm(48'haa, {16'h86dd, 112'h0}, 1'b0, 2'h0, 16'h86dd);
      $display("test control done");
      wr(8'h04, 32'h00000000);
      for (int k = 0; k < 9; k++)
         frm(48'h0, {16'h88e5, tci[k], sl[k], k == 8 ? 32'h0 : 32'h1, 64'h0}, 1'b0, tag[k], 16'h88e5);
      frm(48'h0, {32'h81000001, 16'h88e5, 16'h0c00, 32'h1, 32'h0}, 1'b0, 2'h0, 16'h88e5);
      wr(8'h00, 32'h00000002);
      frm(48'h0, {32'h81000001, 16'h88e5, 16'h0c00, 32'h1, 32'h0}, 1'b0, 2'h1, 16'h88e5);
      $display("test sectag done");
      p.stall = 3;
      wr(8'h00, 32'h00000024);
      frm(48'h0, {32'h8100a123, 16'h0800, 80'h0}, 1'b0, 2'h0, 16'h0800);
      vchk(4'b1010, 3'h5);
      chk("vid", 12'h123, res_vid);
      wr(8'h28, 32'h00facc88);
      frm(48'h0, {32'h88a82456, 32'h81006789, 16'h0800, 48'h0}, 1'b0, 2'h0, 16'h0800);
      vchk(4'b1101, 3'h1);
      chk("inner up", 3'h6, res_inner_up);
      chk("inner vid", 12'h789, res_inner_vid);
      frm(48'h0, plain, 1'b0, 2'h0, 16'h0800);
      vchk(4'b0000, 3'h2);
      wr(8'h00, 32'h00000020);
      frm(48'h0, {32'h8100a123, 16'h0800, 80'h0}, 1'b0, 2'h0, 16'h0800);
      vchk(4'b1010, 3'h2);
      $display("test vlan done");
      p.mem[0] = 8'h03;
      @(posedge ref_clk);
      p.send(1, 1'b1);
      seen = 1'b0;
      repeat (6) @(posedge ref_clk) seen |= res_valid;
      chk("status result", 1'b0, seen);
      $display("test status done");
      wrap_up;
   end
endmodule // msc_static_classifier_test
`default_nettype wire
